/* File: hw/emdio_slave.sv */
// extended management slave: two-wire management link to 32-bit register space
// assumes mdc_i/mdio_i/straps/device reset are asynchronous pins, register
// space answers reg_rsp_i combinationally in the cycle of a read request
//
// What this block does
// - answer only phy addresses 16 to 31
// - active only when mode strap reads 01
// - phy 3:0 and reg field map address
// - reg bit 0 picks half, high byte first
// - two opposite halves form one dword access
// - sample and launch on rising management clock
// - data line released except returning read data
// - read: z, then low, sixteen bits, release
// - same half read twice restarts the pair
// - sixteen-bit registers need no companion read
// - read side effects only after second half
// - dword captured at first half, held
// - unused addresses read as driven zeros
// - reset end drops pending read half
// - never drive the line during writes
// - same half written twice discards transfer
module emdio_slave
  import emdio_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [31:0] wb_dat_i,
  input  wire logic [3:0]  wb_sel_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        mdc_i,
  input  wire logic        mdio_i,
  output logic             mdio_o,
  output logic             mdio_oe_o,
  input  wire logic [1:0]  mode_strap_i,
  input  wire logic        dev_in_reset_i,
  output em_reg_req_t      reg_req_o,
  input  wire em_reg_rsp_t reg_rsp_i
);

  logic [4:0]  sync_q;
  logic        mdc_s;
  logic        mdio_s;
  logic [1:0]  strap_s;
  logic        devrst_s;

  emdio_sync #(.WIDTH(5)) u_sync (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .d_i   ({mdc_i, mdio_i, mode_strap_i, dev_in_reset_i}),
    .q_o   (sync_q)
  );

  assign mdc_s    = sync_q[4];
  assign mdio_s   = sync_q[3];
  assign strap_s  = sync_q[2:1];
  assign devrst_s = sync_q[0];

  // edge detection and strap capture
  logic        mdc_d_ff, nxt_mdc_d;
  logic        devrst_d_ff, nxt_devrst_d;
  logic [1:0]  strap_cnt_ff, nxt_strap_cnt;
  logic        strap_ok_ff, nxt_strap_ok;
  logic        mdc_rise;
  logic        rst_end;
  logic        active;
  logic        ctrl_en_ff, nxt_ctrl_en;

  always_comb
  begin
    nxt_mdc_d     = mdc_s;
    nxt_devrst_d  = devrst_s;
    nxt_strap_cnt = (strap_cnt_ff == 2'h3) ? strap_cnt_ff : strap_cnt_ff + 2'h1;
    nxt_strap_ok  = strap_ok_ff;
    if (strap_cnt_ff == EM_STRAP_TAKE)
      nxt_strap_ok = (strap_s == EM_MODE_EXT);
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      mdc_d_ff     <= 1'b0;
      devrst_d_ff  <= 1'b0;
      strap_cnt_ff <= 2'h0;
      strap_ok_ff  <= 1'b0;
    end
    else
    begin
      mdc_d_ff     <= nxt_mdc_d;
      devrst_d_ff  <= nxt_devrst_d;
      strap_cnt_ff <= nxt_strap_cnt;
      strap_ok_ff  <= nxt_strap_ok;
    end
  end

  assign mdc_rise = mdc_s & ~mdc_d_ff;
  assign rst_end  = devrst_d_ff & ~devrst_s;
  assign active   = strap_ok_ff & ctrl_en_ff;

  // frame engine and pairing
  em_state_t   state_ff, nxt_state;
  logic [5:0]  pre_cnt_ff, nxt_pre_cnt;
  logic [3:0]  bit_cnt_ff, nxt_bit_cnt;
  em_hdr_t     hdr_ff, nxt_hdr;
  logic        is_rd_ff, nxt_is_rd;
  logic        rd_second_ff, nxt_rd_second;
  logic [15:0] rsh_ff, nxt_rsh;
  logic [15:0] wsh_ff, nxt_wsh;
  logic [31:0] hold_ff, nxt_hold;
  logic        rd_pend_ff, nxt_rd_pend;
  em_loc_t     rd_loc_ff, nxt_rd_loc;
  logic        wr_pend_ff, nxt_wr_pend;
  em_loc_t     wr_loc_ff, nxt_wr_loc;
  logic [15:0] wr_half_ff, nxt_wr_half;
  logic [15:0] rd_err_ff, nxt_rd_err;
  logic [15:0] wr_err_ff, nxt_wr_err;
  logic        mdio_ff, nxt_mdio;
  logic        mdio_oe_ff, nxt_mdio_oe;
  em_reg_req_t req_ff, nxt_req;

  em_hdr_t     h_new;
  em_loc_t     loc_new;
  em_loc_t     loc_cur;
  logic        hdr_done;
  logic        data_done;
  logic        sel_new;
  logic        rd_pair;
  logic        rd_same;
  logic        wr_pair;
  logic        wr_same;
  logic [15:0] half;
  logic [15:0] wd;

  assign h_new     = em_hdr_t'({hdr_ff[10:0], mdio_s});
  assign loc_new   = em_loc(h_new);
  assign loc_cur   = em_loc(hdr_ff);
  assign hdr_done  = mdc_rise && (state_ff == EM_HDR) && (bit_cnt_ff == EM_HDR_LAST);
  assign data_done = mdc_rise && (state_ff == EM_DATA) && (bit_cnt_ff == EM_DATA_LAST);
  assign sel_new   = active && h_new.phy[EM_PHY_SEL_BIT]
                     && (h_new.op == EM_OP_RD || h_new.op == EM_OP_WR);
  assign rd_pair   = rd_pend_ff && (rd_loc_ff.dw == loc_new.dw) && (rd_loc_ff.ws != loc_new.ws);
  assign rd_same   = rd_pend_ff && (rd_loc_ff == loc_new);
  assign wr_pair   = wr_pend_ff && (wr_loc_ff.dw == loc_cur.dw) && (wr_loc_ff.ws != loc_cur.ws);
  assign wr_same   = wr_pend_ff && (wr_loc_ff == loc_cur);
  assign half      = hdr_ff.regf[0] ? hold_ff[31:16] : hold_ff[15:0];
  assign wd        = {wsh_ff[14:0], mdio_s};

  always_comb
  begin
    nxt_state     = state_ff;
    nxt_pre_cnt   = pre_cnt_ff;
    nxt_bit_cnt   = bit_cnt_ff;
    nxt_hdr       = hdr_ff;
    nxt_is_rd     = is_rd_ff;
    nxt_rd_second = rd_second_ff;
    nxt_rsh       = rsh_ff;
    nxt_wsh       = wsh_ff;
    nxt_hold      = hold_ff;
    nxt_rd_pend   = rd_pend_ff;
    nxt_rd_loc    = rd_loc_ff;
    nxt_wr_pend   = wr_pend_ff;
    nxt_wr_loc    = wr_loc_ff;
    nxt_wr_half   = wr_half_ff;
    nxt_rd_err    = rd_err_ff;
    nxt_wr_err    = wr_err_ff;
    nxt_mdio      = mdio_ff;
    nxt_mdio_oe   = mdio_oe_ff;
    nxt_req       = req_ff;
    nxt_req.rd    = 1'b0;
    nxt_req.wr    = 1'b0;
    nxt_req.done  = 1'b0;
    if (req_ff.rd)
    begin
      nxt_hold = reg_rsp_i.unused ? 32'h0 : reg_rsp_i.rdata;
      if (reg_rsp_i.rd16)
        nxt_rd_pend = 1'b0;
    end
    if (rst_end)
      nxt_rd_pend = 1'b0;
    if (!active)
    begin
      nxt_state   = EM_IDLE;
      nxt_pre_cnt = 6'h0;
      nxt_mdio_oe = 1'b0;
      nxt_mdio    = 1'b0;
    end
    else if (mdc_rise)
    begin
      case (state_ff)
        EM_IDLE:
        begin
          if (mdio_s)
            nxt_pre_cnt = (pre_cnt_ff == EM_PRE_LEN) ? pre_cnt_ff : pre_cnt_ff + 6'h1;
          else
          begin
            if (pre_cnt_ff == EM_PRE_LEN)
              nxt_state = EM_START;
            nxt_pre_cnt = 6'h0;
          end
        end
        EM_START:
        begin
          nxt_state   = mdio_s ? EM_HDR : EM_IDLE;
          nxt_bit_cnt = 4'h0;
        end
        EM_HDR:
        begin
          nxt_hdr     = h_new;
          nxt_bit_cnt = bit_cnt_ff + 4'h1;
          if (bit_cnt_ff == EM_HDR_LAST)
          begin
            nxt_bit_cnt = 4'h0;
            nxt_state   = sel_new ? EM_TA : EM_IDLE;
            nxt_is_rd   = (h_new.op == EM_OP_RD);
            if (sel_new && h_new.op == EM_OP_RD)
            begin
              nxt_wr_pend   = 1'b0;
              nxt_rd_second = rd_pair;
              if (rd_pair)
                nxt_rd_pend = 1'b0;
              else
              begin
                if (rd_pend_ff)
                  nxt_rd_err = rd_err_ff + 16'h1;
                nxt_req.rd   = 1'b1;
                nxt_req.addr = loc_new.dw;
                nxt_rd_pend  = 1'b1;
                nxt_rd_loc   = loc_new;
              end
            end
            else if (sel_new)
              nxt_rd_pend = 1'b0;
          end
        end
        EM_TA:
        begin
          if (bit_cnt_ff == 4'h0)
          begin
            nxt_bit_cnt = 4'h1;
            if (is_rd_ff)
            begin
              nxt_mdio_oe = 1'b1;
              nxt_mdio    = 1'b0;
            end
          end
          else
          begin
            nxt_state   = EM_DATA;
            nxt_bit_cnt = 4'h0;
            if (is_rd_ff)
            begin
              nxt_mdio = half[15];
              nxt_rsh  = {half[14:0], 1'b0};
            end
          end
        end
        EM_DATA:
        begin
          nxt_bit_cnt = bit_cnt_ff + 4'h1;
          if (is_rd_ff)
          begin
            nxt_mdio = rsh_ff[15];
            nxt_rsh  = {rsh_ff[14:0], 1'b0};
          end
          else
            nxt_wsh = wd;
          if (bit_cnt_ff == EM_DATA_LAST)
          begin
            nxt_state   = EM_IDLE;
            nxt_pre_cnt = 6'h0;
            nxt_bit_cnt = 4'h0;
            if (is_rd_ff)
            begin
              nxt_mdio_oe  = 1'b0;
              nxt_mdio     = 1'b0;
              nxt_req.done = rd_second_ff;
              nxt_req.addr = loc_cur.dw;
            end
            else if (wr_pair)
            begin
              nxt_req.wr    = 1'b1;
              nxt_req.addr  = loc_cur.dw;
              nxt_req.wdata = loc_cur.ws ? {wd, wr_half_ff} : {wr_half_ff, wd};
              nxt_wr_pend   = 1'b0;
            end
            else if (wr_same)
            begin
              nxt_wr_pend = 1'b0;
              nxt_wr_err  = wr_err_ff + 16'h1;
            end
            else
            begin
              nxt_wr_pend = 1'b1;
              nxt_wr_loc  = loc_cur;
              nxt_wr_half = wd;
            end
          end
        end
        default:
          nxt_state = EM_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      state_ff     <= EM_IDLE;
      pre_cnt_ff   <= 6'h0;
      bit_cnt_ff   <= 4'h0;
      hdr_ff       <= '0;
      is_rd_ff     <= 1'b0;
      rd_second_ff <= 1'b0;
      rsh_ff       <= 16'h0;
      wsh_ff       <= 16'h0;
      hold_ff      <= 32'h0;
      rd_pend_ff   <= 1'b0;
      rd_loc_ff    <= '0;
      wr_pend_ff   <= 1'b0;
      wr_loc_ff    <= '0;
      wr_half_ff   <= 16'h0;
      rd_err_ff    <= 16'h0;
      wr_err_ff    <= 16'h0;
      mdio_ff      <= 1'b0;
      mdio_oe_ff   <= 1'b0;
      req_ff       <= '0;
    end
    else
    begin
      state_ff     <= nxt_state;
      pre_cnt_ff   <= nxt_pre_cnt;
      bit_cnt_ff   <= nxt_bit_cnt;
      hdr_ff       <= nxt_hdr;
      is_rd_ff     <= nxt_is_rd;
      rd_second_ff <= nxt_rd_second;
      rsh_ff       <= nxt_rsh;
      wsh_ff       <= nxt_wsh;
      hold_ff      <= nxt_hold;
      rd_pend_ff   <= nxt_rd_pend;
      rd_loc_ff    <= nxt_rd_loc;
      wr_pend_ff   <= nxt_wr_pend;
      wr_loc_ff    <= nxt_wr_loc;
      wr_half_ff   <= nxt_wr_half;
      rd_err_ff    <= nxt_rd_err;
      wr_err_ff    <= nxt_wr_err;
      mdio_ff      <= nxt_mdio;
      mdio_oe_ff   <= nxt_mdio_oe;
      req_ff       <= nxt_req;
    end
  end

  assign mdio_o    = mdio_ff;
  assign mdio_oe_o = mdio_oe_ff;
  assign reg_req_o = req_ff;

  // wishbone slave, ack one cycle after strobe
  logic        ack_ff, nxt_ack;
  logic [31:0] dat_ff, nxt_dat;

  always_comb
  begin
    nxt_ack     = wb_cyc_i & wb_stb_i & ~ack_ff;
    nxt_dat     = dat_ff;
    nxt_ctrl_en = ctrl_en_ff;
    if (nxt_ack && !wb_we_i)
    begin
      nxt_dat = 32'h0;
      case (wb_adr_i)
        EM_CTRL_OFS:
          nxt_dat[EM_CTRL_EN_BIT] = ctrl_en_ff;
        EM_STAT_OFS:
        begin
          nxt_dat[EM_STAT_ACT_BIT] = active;
          nxt_dat[EM_STAT_RDP_BIT] = rd_pend_ff;
          nxt_dat[EM_STAT_WRP_BIT] = wr_pend_ff;
        end
        EM_ERR_OFS:
        begin
          nxt_dat[EM_ERR_RD_LSB +: 16] = rd_err_ff;
          nxt_dat[EM_ERR_WR_LSB +: 16] = wr_err_ff;
        end
        default:
          nxt_dat = 32'h0;
      endcase
    end
    if (nxt_ack && wb_we_i && wb_adr_i == EM_CTRL_OFS && wb_sel_i[0])
      nxt_ctrl_en = wb_dat_i[EM_CTRL_EN_BIT];
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack_ff     <= 1'b0;
      dat_ff     <= 32'h0;
      ctrl_en_ff <= EM_CTRL_EN_RST;
    end
    else
    begin
      ack_ff     <= nxt_ack;
      dat_ff     <= nxt_dat;
      ctrl_en_ff <= nxt_ctrl_en;
    end
  end

  assign wb_ack_o = ack_ff;
  assign wb_dat_o = dat_ff;

  // checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  chk_phy_upper_only: assert property (hdr_done && !h_new.phy[EM_PHY_SEL_BIT]
    |=> state_ff == EM_IDLE) else $error("lower phy address accepted");
  chk_strap_gate: assert property (!active |=> !mdio_oe_o)
    else $error("line driven while inactive");
  chk_addr_map: assert property (hdr_done && sel_new && h_new.op == EM_OP_RD && !rd_pair
    |=> reg_req_o.rd && reg_req_o.addr == {hdr_ff.phy[3:0], hdr_ff.regf[4:1]})
    else $error("bad register address mapping");
  chk_half_order: assert property (mdc_rise && state_ff == EM_TA && bit_cnt_ff == 4'h1
    && is_rd_ff |=> mdio_o == (hdr_ff.regf[0] ? hold_ff[31] : hold_ff[15]))
    else $error("wrong first data bit");
  chk_write_pair: assert property (data_done && !is_rd_ff && wr_pair
    |=> reg_req_o.wr ##1 !reg_req_o.wr) else $error("paired write not committed once");
  chk_launch_edge: assert property (active && $changed(mdio_oe_o) |-> $past(mdc_rise))
    else $error("enable changed off a clock edge");
  chk_idle_quiet: assert property (mdio_oe_o
    |-> is_rd_ff && (state_ff == EM_TA || state_ff == EM_DATA))
    else $error("line driven outside read data");
  chk_ta_z_then_low: assert property (mdc_rise && state_ff == EM_TA && bit_cnt_ff == 4'h0
    && is_rd_ff |-> !mdio_oe_o ##1 (mdio_oe_o && !mdio_o))
    else $error("turnaround not z then low");
  chk_rd_same_half: assert property (hdr_done && sel_new && h_new.op == EM_OP_RD && rd_same
    |=> rd_err_ff == $past(rd_err_ff) + 16'h1 && reg_req_o.rd)
    else $error("same half read not restarted");
  chk_rd_commit_late: assert property (reg_req_o.done
    |-> $past(data_done) && $past(rd_second_ff)) else $error("early read commit");
  chk_hold_stable: assert property (!reg_req_o.rd |=> $stable(hold_ff))
    else $error("held dword changed");
  chk_unused_zero: assert property (reg_req_o.rd && reg_rsp_i.unused
    |=> hold_ff == 32'h0) else $error("unused address not zero");
  chk_reset_drop: assert property (rst_end |=> !rd_pend_ff || reg_req_o.rd)
    else $error("pending half kept after reset");
  chk_write_quiet: assert property (!is_rd_ff && state_ff != EM_IDLE |-> !mdio_oe_o)
    else $error("line driven during write");
  chk_write_same: assert property (data_done && !is_rd_ff && wr_same
    |=> !reg_req_o.wr && !wr_pend_ff) else $error("same half write not discarded");

  cov_read_pair: cover property (reg_req_o.done);
  cov_write_pair: cover property (reg_req_o.wr);
  cov_read_restart: cover property (hdr_done && sel_new && rd_same);
  cov_read_16: cover property (reg_req_o.rd && reg_rsp_i.rd16);

endmodule

/* File: hw/emdio_pkg.sv */
// constants, carriers and states of the extended management slave
// assumes a 40 MHz system clock and a management clock of at most 5 MHz
package emdio_pkg;

  // wishbone register offsets (byte addresses)
  localparam logic [7:0] EM_CTRL_OFS      = 8'h00;
  localparam logic [7:0] EM_STAT_OFS      = 8'h04;
  localparam logic [7:0] EM_ERR_OFS       = 8'h08;

  // field positions
  localparam int         EM_CTRL_EN_BIT   = 0;
  localparam int         EM_STAT_ACT_BIT  = 0;
  localparam int         EM_STAT_RDP_BIT  = 1;
  localparam int         EM_STAT_WRP_BIT  = 2;
  localparam int         EM_ERR_RD_LSB    = 0;
  localparam int         EM_ERR_WR_LSB    = 16;
  localparam int         EM_PHY_SEL_BIT   = 4;

  // reset values
  localparam logic       EM_CTRL_EN_RST   = 1'b1;

  // frame constants
  localparam logic [1:0] EM_MODE_EXT      = 2'h1;
  localparam logic [1:0] EM_OP_RD         = 2'h2;
  localparam logic [1:0] EM_OP_WR         = 2'h1;
  localparam logic [5:0] EM_PRE_LEN       = 6'h20;
  localparam logic [3:0] EM_HDR_LAST      = 4'hb;
  localparam logic [3:0] EM_DATA_LAST     = 4'hf;
  localparam logic [1:0] EM_STRAP_TAKE    = 2'h2;

  typedef struct packed {
    logic [1:0] op;
    logic [4:0] phy;
    logic [4:0] regf;
  } em_hdr_t;

  // dword address bits 9:2 and half-word select
  typedef struct packed {
    logic [7:0] dw;
    logic       ws;
  } em_loc_t;

  typedef struct packed {
    logic        rd;
    logic        wr;
    logic        done;
    logic [7:0]  addr;
    logic [31:0] wdata;
  } em_reg_req_t;

  typedef struct packed {
    logic [31:0] rdata;
    logic        unused;
    logic        rd16;
  } em_reg_rsp_t;

  typedef enum logic [4:0] {
    EM_IDLE  = 5'h01,
    EM_START = 5'h02,
    EM_HDR   = 5'h04,
    EM_TA    = 5'h08,
    EM_DATA  = 5'h10
  } em_state_t;

  function automatic em_loc_t em_loc(input em_hdr_t h);
    em_loc = em_loc_t'({h.phy[3:0], h.regf});
  endfunction

endpackage

/* File: hw/emdio_sync.sv */
// two-flop synchroniser for pins from outside the system clock domain
// assumes one system clock and a synchronous active-high reset
module emdio_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic [WIDTH-1:0] d_i,
  output logic      [WIDTH-1:0] q_o
);

  logic [WIDTH-1:0] meta_ff;
  logic [WIDTH-1:0] q_ff;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      meta_ff <= '0;
      q_ff    <= '0;
    end
    else
    begin
      meta_ff <= d_i;
      q_ff    <= meta_ff;
    end
  end

  assign q_o = q_ff;

endmodule

/* File: bench/emdio_host.sv */
// host model: management master driving clock and data of the link
// assumes a pull-up on the data line and the bench's 40 mhz system clock
module emdio_host
  import emdio_pkg::*;
(
  input  wire logic clk_i,
  input  wire logic dev_oe_i,
  input  wire logic dev_d_i,
  output logic      mdc_o,
  output logic      mdio_o,
  output logic      rd_frame_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic host_oe = 1'b0;
  logic host_d  = 1'b1;
  initial mdc_o = 1'b0;
  initial rd_frame_o = 1'b0;
  // resolved wire, pulled high when released
  assign mdio_o = dev_oe_i ? dev_d_i : (host_oe ? host_d : 1'b1);

  // one 200 ns clock period, clock stands low outside frames
  task automatic cyc(input logic oe, input logic d, output logic s);
    @(posedge clk_i);
    mdc_o <= 1'b1;
    s = mdio_o;
    @(posedge clk_i);
    host_oe <= oe;
    host_d <= d;
    repeat (3) @(posedge clk_i);
    mdc_o <= 1'b0;
    repeat (3) @(posedge clk_i);
  endtask

  // whole frame; r holds both turnaround samples and sixteen data samples
  task automatic frame(input logic [1:0] op, input logic [4:0] phy, input logic [4:0] rf,
                       input logic [15:0] wd, output logic [17:0] r);
    logic [63:0] bits;
    logic        s;
    bits = {32'hffffffff, 2'h1, op, phy, rf, 2'h2, wd};
    rd_frame_o = (op == EM_OP_RD);
    for (int i = 63; i >= (op == EM_OP_WR ? 0 : 18); i--)
      cyc(1'b1, bits[i], s);
    for (int j = 0; j < 19; j++)
    begin
      cyc(1'b0, 1'b1, s);
      if (j > 0)
        r = {r[16:0], s};
    end
    rd_frame_o = 1'b0;
  endtask
endmodule

/* File: bench/emdio_slave_tb.sv */
// testbench of the extended management slave, host model and register space
// assumes the slave answers wishbone in one cycle and reads reg_rsp_i combinationally
module emdio_slave_tb
  import emdio_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int LIMIT = 40000;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc = 1'b0;
  logic        stb = 1'b0;
  logic        we = 1'b0;
  logic [7:0]  adr = 8'h00;
  logic [31:0] wdat = 32'h0;
  logic [3:0]  sel = 4'h0;
  logic [31:0] dat_o;
  logic        ack;
  logic        mdc;
  logic        mdio;
  logic        oe;
  logic        d_o;
  logic        rd_frame;
  logic [1:0]  strap = 2'h1;
  logic        dev_rst = 1'b0;
  em_reg_req_t req;
  em_reg_rsp_t rsp;
  logic [31:0] mem [256];
  logic [39:0] last_wr;
  int          rd_n = 0;
  int          done_n = 0;
  int          wr_n = 0;
  int          fails = 0;
  int          checked = 0;
  int          cycles = 0;

  always #12.5 clk_i = ~clk_i;

  emdio_slave i_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(wdat), .wb_sel_i(sel), .wb_dat_o(dat_o),
    .wb_ack_o(ack), .mdc_i(mdc), .mdio_i(mdio), .mdio_o(d_o), .mdio_oe_o(oe),
    .mode_strap_i(strap), .dev_in_reset_i(dev_rst), .reg_req_o(req), .reg_rsp_i(rsp));
  emdio_host i_host (.clk_i(clk_i), .dev_oe_i(oe), .dev_d_i(d_o), .mdc_o(mdc),
    .mdio_o(mdio), .rd_frame_o(rd_frame));

  // register space: top sixteen dwords unused, dword 0x10 is 16-bit readable
  always_comb
  begin
    rsp.rdata = mem[req.addr];
    rsp.unused = (req.addr[7:4] == 4'hf);
    rsp.rd16 = (req.addr == 8'h10);
  end

  task automatic chk(input logic [31:0] a, input logic [31:0] e);
    checked++;
    if (a !== e)
    begin
      fails++;
      $display("mismatch at %0t: got %h expected %h", $time, a, e);
    end
  endtask

  task automatic results();
    if (fails == 0 && checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  always @(posedge clk_i)
  begin
    cycles++;
    rd_n += int'(req.rd);
    done_n += int'(req.done);
    wr_n += int'(req.wr);
    if (req.wr)
      last_wr = {req.addr, req.wdata};
    chk({31'h0, oe & ~rd_frame}, 32'h0);
    if (cycles == LIMIT)
    begin
      fails++;
      results();
    end
  end

  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                    output logic [31:0] q);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= 4'hf;
    do @(posedge clk_i); while (ack !== 1'b1);
    q = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask

  task automatic rdh(input logic [7:0] dw, input logic ws, input logic [15:0] e);
    logic [17:0] r;
    i_host.frame(EM_OP_RD, {1'b1, dw[7:4]}, {dw[3:0], ws}, 16'h0, r);
    chk({14'h0, r}, {14'h2, e});
  endtask

  task automatic wrh(input logic [7:0] dw, input logic ws, input logic [15:0] d);
    logic [17:0] r;
    i_host.frame(EM_OP_WR, {1'b1, dw[7:4]}, {dw[3:0], ws}, d, r);
  endtask

  task automatic reset_dut();
    rst_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (4) @(posedge clk_i);
  endtask

  task automatic t_regs();
    logic [31:0] q;
    wb(1'b0, EM_CTRL_OFS, 32'h0, q);
    chk(q, 32'h1);
    wb(1'b1, EM_STAT_OFS, 32'hffffffff, q);
    wb(1'b0, EM_STAT_OFS, 32'h0, q);
    chk(q, 32'h1);
    wb(1'b0, EM_ERR_OFS, 32'h0, q);
    chk(q, 32'h0);
    wb(1'b0, 8'h0c, 32'h0, q);
    chk(q, 32'h0);
  endtask

  task automatic t_rd_pair();
    logic [31:0] e;
    int          n;
    int          d;
    n = rd_n;
    d = done_n;
    e = mem[8'h25];
    rdh(8'h25, 1'b1, e[31:16]);
    chk(done_n, d);
    mem[8'h25] = ~e;
    rdh(8'h25, 1'b0, e[15:0]);
    e = mem[8'h3c];
    rdh(8'h3c, 1'b0, e[15:0]);
    rdh(8'h3c, 1'b1, e[31:16]);
    chk(rd_n - n, 2);
    chk(done_n - d, 2);
  endtask

  task automatic t_restart();
    logic [31:0] q0;
    logic [31:0] q;
    int          d;
    d = done_n;
    wb(1'b0, EM_ERR_OFS, 32'h0, q0);
    rdh(8'h3c, 1'b0, mem[8'h3c][15:0]);
    rdh(8'h3c, 1'b0, mem[8'h3c][15:0]);
    wb(1'b0, EM_ERR_OFS, 32'h0, q);
    chk(q, q0 + 32'h1);
    rdh(8'h3c, 1'b1, mem[8'h3c][31:16]);
    chk(done_n - d, 1);
  endtask

  task automatic t_rd16_unused();
    logic [31:0] q0;
    logic [31:0] q;
    wb(1'b0, EM_ERR_OFS, 32'h0, q0);
    rdh(8'h10, 1'b0, mem[8'h10][15:0]);
    rdh(8'h25, 1'b0, mem[8'h25][15:0]);
    rdh(8'h25, 1'b1, mem[8'h25][31:16]);
    rdh(8'hf0, 1'b1, 16'h0);
    rdh(8'hf0, 1'b0, 16'h0);
    wb(1'b0, EM_ERR_OFS, 32'h0, q);
    chk(q, q0);
  endtask

  task automatic t_write();
    logic [31:0] q;
    int          n;
    n = wr_n;
    wrh(8'h41, 1'b1, 16'hbeef);
    chk(wr_n, n);
    wrh(8'h41, 1'b0, 16'h1234);
    chk({24'h0, last_wr[39:32]}, 32'h41);
    chk(last_wr[31:0], 32'hbeef1234);
    wrh(8'h42, 1'b0, 16'h5678);
    wrh(8'h42, 1'b1, 16'h9abc);
    chk({24'h0, last_wr[39:32]}, 32'h42);
    chk(last_wr[31:0], 32'h9abc5678);
    wrh(8'h43, 1'b0, 16'h1111);
    wrh(8'h43, 1'b0, 16'h2222);
    chk(wr_n - n, 2);
    wb(1'b0, EM_ERR_OFS, 32'h0, q);
    chk({16'h0, q[31:16]}, 32'h1);
  endtask

  task automatic t_devrst();
    int n;
    n = rd_n;
    rdh(8'h3c, 1'b1, mem[8'h3c][31:16]);
    dev_rst <= 1'b1;
    repeat (10) @(posedge clk_i);
    dev_rst <= 1'b0;
    repeat (10) @(posedge clk_i);
    mem[8'h3c] = 32'hc0de7e57;
    rdh(8'h3c, 1'b0, 16'h7e57);
    chk(rd_n - n, 2);
  endtask

  task automatic t_select();
    logic [17:0] r;
    logic [31:0] q;
    int          n;
    n = rd_n;
    i_host.frame(EM_OP_RD, 5'h05, 5'h0a, 16'h0, r);
    chk({14'h0, r}, 32'h3ffff);
    i_host.frame(2'h3, 5'h12, 5'h0a, 16'h0, r);
    chk({14'h0, r}, 32'h3ffff);
    wb(1'b1, EM_CTRL_OFS, 32'h0, q);
    wb(1'b0, EM_STAT_OFS, 32'h0, q);
    chk({31'h0, q[0]}, 32'h0);
    i_host.frame(EM_OP_RD, 5'h12, 5'h0a, 16'h0, r);
    chk({14'h0, r}, 32'h3ffff);
    wb(1'b1, EM_CTRL_OFS, 32'h1, q);
    strap <= 2'h2;
    reset_dut();
    i_host.frame(EM_OP_RD, 5'h12, 5'h0a, 16'h0, r);
    chk({14'h0, r}, 32'h3ffff);
    chk(rd_n, n);
    strap <= 2'h1;
    reset_dut();
    rdh(8'h25, 1'b1, mem[8'h25][31:16]);
  endtask

  initial
  begin
    for (int i = 0; i < 256; i++)
      mem[i] = {4{i[7:0]}} ^ 32'h5aa5c33c;
    reset_dut();
    t_regs();
    t_rd_pair();
    t_restart();
    t_rd16_unused();
    t_write();
    t_devrst();
    t_select();
    results();
  end
endmodule
